/* src/decade_counter_pkg.sv */
package decade_counter_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Timing of the sampling clock
	localparam int REF_CLK_MHZ = 40; // Sampling clock rate
	localparam int REF_CLK_PERIOD_NS = 1000 / REF_CLK_MHZ; // 25 ns period
	localparam int SYNC_STAGES = 2; // Flip-flops before any pin is read

	////////////////////////////////////////////////////////////////////////////
	// Widths and field values
	localparam int COUNT_WIDTH = 4; // Whole counter width
	localparam int QUINT_WIDTH = 3; // Divide-by-five stage width
	localparam logic [3:0] COUNT_RESET = 4'h0; // Counter value after clear
	localparam logic [2:0] QUINT_LAST = 3'h4; // Last state of the upper cycle
	localparam logic [2:0] QUINT_FIRST = 3'h0; // First state of the upper cycle
	localparam logic [2:0] QUINT_STEP = 3'h1; // Upper stage increment
	localparam logic [1:0] QUINT_ESCAPE_MASK = 2'h3; // Keeps low bits of unused states

	////////////////////////////////////////////////////////////////////////////
	// Pin group as sampled from the board
	typedef struct packed {
		logic div2_clk; // First stage clock level
		logic div5_clk; // Second stage clock level
		logic clear_n; // Master clear, low active
		logic load_n; // Preset load, low active
		logic [3:0] preset; // Preset data
	} pin_in_type;

	localparam int PIN_WIDTH = $bits(pin_in_type); // Width of the pin group
	localparam logic [7:0] PIN_IDLE = 8'h30; // Clocks low, clear and load inactive

endpackage : decade_counter_pkg

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
	import decade_counter_pkg::*;
#(
	parameter int WIDTH = PIN_WIDTH, // Bits carried
	parameter int STAGES = SYNC_STAGES, // Flip-flops in the chain
	parameter logic [WIDTH-1:0] IDLE = PIN_IDLE // Value held during reset
) (
	input wire logic ref_clk, // Sampling clock
	input wire logic rst, // Synchronous reset, high active
	input wire logic [WIDTH-1:0] async_in, // Pins from the board
	output logic [WIDTH-1:0] sync_out // Pins in the clock domain
);

	////////////////////////////////////////////////////////////////////////////
	// Refuse chains too short to settle metastability
	if (STAGES < 2) begin : g_bad_stages
		$error("pin_sync needs at least two stages");
	end

	logic [WIDTH-1:0] chain_q [STAGES]; // Synchroniser chain

	////////////////////////////////////////////////////////////////////////////
	// Shift the pins through the chain; only the next stage reads a stage
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < STAGES; i++) chain_q[i] <= IDLE;
		end else begin
			chain_q[0] <= async_in;
			for (int i = 1; i < STAGES; i++) chain_q[i] <= chain_q[i-1];
		end
	end

	assign sync_out = chain_q[STAGES-1]; // Last stage is safe to read

endmodule : pin_sync

/* src/decade_counter.sv */
`timescale 1ns/1ps
module decade_counter
	import decade_counter_pkg::*;
#(
	parameter int STAGES = SYNC_STAGES // Synchroniser depth for the pins
) (
	input wire logic ref_clk, // 40 MHz sampling clock
	input wire logic rst, // Synchronous reset, high active
	input wire logic div2_clock_in, // Divide-by-two stage clock pin
	input wire logic div5_clock_in, // Divide-by-five stage clock pin
	input wire logic clear_all_n, // Master clear pin, low active
	input wire logic preset_load_n, // Preset load pin, low active
	input wire logic [3:0] preset_value_in, // Preset data pins
	output logic [3:0] count_out, // Counter value
	output logic count_out_lsb, // Lowest bit, divide-by-two stage
	output logic count_out_msb // Highest bit of the divide-by-five stage
);

	////////////////////////////////////////////////////////////////////////////
	// Refuse a width that the stage split cannot serve
	if (COUNT_WIDTH != QUINT_WIDTH + 1) begin : g_bad_width
		$error("counter must be one bit plus the five-state stage");
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	pin_in_type pins_raw; // Pin group before synchronising
	pin_in_type pins_s; // Pin group in the clock domain
	logic div2_prev_q; // Last level of the first clock
	logic div5_prev_q; // Last level of the second clock
	logic lsb_q; // Divide-by-two flip-flop
	logic lsb_d; // Its next value
	logic [2:0] quint_q; // Divide-by-five flip-flops
	logic [2:0] quint_d; // Their next value
	logic div2_fall; // Falling edge on the first clock
	logic div5_fall; // Falling edge on the second clock
	logic clearing; // Clear is active
	logic loading; // Load is active and clear is not
	logic counting; // Neither clear nor load
	logic quint_wrap; // Upper stage at its last state
	logic quint_unused; // Upper stage in a state above four
	logic [2:0] quint_step; // Normal next upper state
	logic [2:0] quint_escape; // Next state out of an unused one

	////////////////////////////////////////////////////////////////////////////
	// Bring every pin into the clock domain
	assign pins_raw = '{
		div2_clk: div2_clock_in,
		div5_clk: div5_clock_in,
		clear_n: clear_all_n,
		load_n: preset_load_n,
		preset: preset_value_in
	};

	pin_sync #(
		.WIDTH(PIN_WIDTH),
		.STAGES(STAGES),
		.IDLE(PIN_IDLE)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Remember the clock levels to find edges
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div2_prev_q <= 1'b0;
			div5_prev_q <= 1'b0;
		end else begin
			div2_prev_q <= pins_s.div2_clk;
			div5_prev_q <= pins_s.div5_clk;
		end
	end

	// Only high-to-low transitions count; rising ones are dropped
	assign div2_fall = div2_prev_q & ~pins_s.div2_clk;
	assign div5_fall = div5_prev_q & ~pins_s.div5_clk;

	////////////////////////////////////////////////////////////////////////////
	// Mode priority: clear, then load, then counting
	// Clear and load act on the synchronised levels, so they take hold three
	// cycles after the pin moves; a pin pulse shorter than one cycle
	// may be lost, which the board must keep in mind
	assign clearing = ~pins_s.clear_n;
	assign loading = pins_s.clear_n & ~pins_s.load_n;
	assign counting = pins_s.clear_n & pins_s.load_n;

	////////////////////////////////////////////////////////////////////////////
	// Upper stage sequence: 0..4 then back to 0
	assign quint_wrap = (quint_q == QUINT_LAST);
	assign quint_unused = (quint_q > QUINT_LAST);
	assign quint_step = quint_q + QUINT_STEP;
	// Unused 5,6,7 drop to 1,2,3, inside the cycle after one edge
	assign quint_escape = {1'b0, quint_q[1:0] & QUINT_ESCAPE_MASK};

	////////////////////////////////////////////////////////////////////////////
	// Next value of the divide-by-two stage, its own clock only
	always_comb begin
		lsb_d = lsb_q;
		if (clearing) begin
			lsb_d = COUNT_RESET[0];
		end else if (loading) begin
			lsb_d = pins_s.preset[0];
		end else if (div2_fall) begin
			lsb_d = ~lsb_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next value of the divide-by-five stage, its own clock only
	always_comb begin
		quint_d = quint_q;
		if (clearing) begin
			quint_d = COUNT_RESET[3:1];
		end else if (loading) begin
			quint_d = pins_s.preset[3:1];
		end else if (div5_fall) begin
			if (quint_wrap) begin
				quint_d = QUINT_FIRST;
			end else if (quint_unused) begin
				quint_d = quint_escape;
			end else begin
				quint_d = quint_step;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stage flip-flops; each stage is updated by its own edge alone, so a
	// chained arrangement ripples through the pins one stage at a time
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lsb_q <= COUNT_RESET[0];
			quint_q <= COUNT_RESET[3:1];
		end else begin
			lsb_q <= lsb_d;
			quint_q <= quint_d;
		end
	end

	// Outputs come straight from the stage flip-flops
	assign count_out = {quint_q, lsb_q};
	assign count_out_lsb = lsb_q;
	assign count_out_msb = quint_q[2];

	////////////////////////////////////////////////////////////////////////////
	// Helper for load checks
	logic [3:0] preset_prev_q; // Preset seen one cycle back
	logic load_prev_q; // Load activity one cycle back

	// Track load and preset for the hold check
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			preset_prev_q <= COUNT_RESET;
			load_prev_q <= 1'b0;
		end else begin
			preset_prev_q <= pins_s.preset;
			load_prev_q <= loading;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	clear_forces_zero_a: assert property (
		clearing |=> (count_out == COUNT_RESET) && $past(clearing)
	) else $error("clear did not zero the counter");

	load_copies_preset_a: assert property (
		loading && (div2_fall || div5_fall) |=> count_out == $past(pins_s.preset)
	) else $error("load did not copy the preset over a clock edge");

	load_tracks_data_a: assert property (
		loading |=> count_out == preset_prev_q
	) else $error("outputs did not follow preset during load");

	load_release_holds_a: assert property (
		load_prev_q && counting && !div2_fall && !div5_fall |-> count_out == preset_prev_q
	) else $error("released load did not keep the preset");

	div2_toggle_a: assert property (
		counting && div2_fall |=> count_out_lsb != $past(count_out_lsb)
	) else $error("first stage did not toggle on its falling edge");

	div2_idle_hold_a: assert property (
		counting && !div2_fall |=> $stable(count_out_lsb)
	) else $error("first stage moved without a falling edge");

	div5_idle_hold_a: assert property (
		counting && !div5_fall |=> count_out[3:1] == $past(count_out[3:1])
	) else $error("upper stage moved without its own falling edge");

	div5_step_wrap_a: assert property (
		counting && div5_fall && quint_q <= QUINT_LAST |=>
			count_out[3:1] == (($past(quint_q) == QUINT_LAST) ? QUINT_FIRST : $past(quint_q) + QUINT_STEP)
	) else $error("upper stage did not count zero to four");

	div5_unused_exit_a: assert property (
		counting && div5_fall && quint_q > QUINT_LAST |=> count_out[3:1] < QUINT_LAST
	) else $error("upper stage stayed in an unused state");

	////////////////////////////////////////////////////////////////////////////
	// Priority and independence of the stages
	// Clear must win even while load is held low at the same time
	clear_beats_load_a: assert property (
		clearing && !pins_s.load_n |=> count_out == COUNT_RESET
	) else $error("load overrode the clear");

	// An edge of the first clock alone must leave the upper stage untouched
	upper_ignores_div2_a: assert property (
		counting && div2_fall && !div5_fall |=> count_out[3:1] == $past(count_out[3:1])
	) else $error("first clock moved the upper stage");

endmodule : decade_counter

/* bench/board_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Board wiring around the counter and the external input frequency
module board_model (
	input wire logic ref_clk, // Sampling clock, paces the pulses
	input wire logic [1:0] wiring_mode, // 0 BCD, 1 bi-quinary, 2 separate
	input wire logic count_out_lsb, // Raw lowest output
	input wire logic count_out_msb, // Raw highest output
	output logic div2_clock_in, // To first stage clock pin
	output logic div5_clock_in // To second stage clock pin
);
	logic ext_a = 1'b0; // Main input frequency
	logic ext_b = 1'b0; // Second source, separate wiring only
	// Raw outputs only feed clocks, never decoded ones
	assign div2_clock_in = (wiring_mode == 2'h1) ? count_out_msb : ext_a;
	assign div5_clock_in = (wiring_mode == 2'h0) ? count_out_lsb : ((wiring_mode == 2'h1) ? ext_a : ext_b);
	////////////////////////////////////////////////////////////////////////////
	// Sets one source level just after a clock edge
	task automatic drive(input logic second, input logic level);
		@(posedge ref_clk);
		#1;
		if (second) begin
			ext_b = level;
		end else begin
			ext_a = level;
		end
	endtask : drive
endmodule : board_model

/* bench/decade_counter_test.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the decade counter
module decade_counter_test;
	import decade_counter_pkg::*;
	logic ref_clk = 1'b0; // Sampling clock
	logic rst = 1'b1; // Held at start
	logic clear_all_n = 1'b1; // Master clear pin
	logic preset_load_n = 1'b1; // Load pin
	logic [3:0] preset_value_in = 4'h0; // Preset pins
	logic [1:0] wiring_mode = 2'h0; // Board wiring choice
	logic div2_clock_in; // From board
	logic div5_clock_in; // From board
	logic [3:0] count_out; // Counter value
	logic count_out_lsb; // Lowest bit
	logic count_out_msb; // Highest bit
	int num_errors = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	logic [2:0] up; // Expected upper stage
	logic lo; // Expected lowest bit
	int highs; // High samples of the lowest bit
	always #12.5 ref_clk = ~ref_clk;
	decade_counter dut_u (.ref_clk(ref_clk), .rst(rst), .div2_clock_in(div2_clock_in),
		.div5_clock_in(div5_clock_in), .clear_all_n(clear_all_n), .preset_load_n(preset_load_n),
		.preset_value_in(preset_value_in), .count_out(count_out), .count_out_lsb(count_out_lsb),
		.count_out_msb(count_out_msb));
	board_model board_u (.ref_clk(ref_clk), .wiring_mode(wiring_mode), .count_out_lsb(count_out_lsb),
		.count_out_msb(count_out_msb), .div2_clock_in(div2_clock_in), .div5_clock_in(div5_clock_in));
	////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task automatic check(input string what, input logic [3:0] exp, input logic [3:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Full pulse, long enough for the chained stage to settle
	task automatic pulse(input logic second);
		board_u.drive(second, 1'b1);
		step(4);
		board_u.drive(second, 1'b0);
		step(12);
	endtask : pulse
	// Rewire only while cleared, so no false edge counts
	task automatic rewire(input logic [1:0] m);
		clear_all_n = 1'b0;
		step(4);
		wiring_mode = m;
		step(4);
		clear_all_n = 1'b1;
		step(4);
	endtask : rewire
	task automatic test_done;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_bcd;
		for (int i = 1; i <= 20; i++) begin
			pulse(1'b0);
			check("bcd", 4'(i % 10), count_out);
			check("lsb_port", {3'h0, count_out[0]}, {3'h0, count_out_lsb});
		end
		board_u.drive(1'b0, 1'b1);
		step(8);
		check("rise_ignored", 4'h0, count_out);
		board_u.drive(1'b0, 1'b0);
		step(12);
		check("fall_counts", 4'h1, count_out);
		// Bring the count to three so the next edge ripples into the upper stage
		repeat (2) pulse(1'b0);
		board_u.drive(1'b0, 1'b1);
		step(4);
		board_u.drive(1'b0, 1'b0);
		for (int k = 0; k < 8 && count_out_lsb !== 1'b0; k++) step(1);
		check("ripple_upper_late", 4'h2, count_out);
		step(12);
		check("ripple_done", 4'h4, count_out);
	endtask : test_bcd
	task automatic test_biquinary;
		rewire(2'h1);
		up = 3'h0;
		lo = 1'b0;
		highs = 0;
		for (int i = 0; i < 10; i++) begin
			pulse(1'b0);
			lo = (up == 3'h4) ? ~lo : lo;
			up = (up == 3'h4) ? 3'h0 : up + 3'h1;
			check("biquinary", {up, lo}, count_out);
			check("msb_port", {3'h0, up[2]}, {3'h0, count_out_msb});
			highs += (count_out_lsb === 1'b1) ? 1 : 0;
		end
		check("duty", 4'h5, 4'(highs));
	endtask : test_biquinary
	task automatic test_separate;
		rewire(2'h2);
		for (int i = 1; i <= 6; i++) begin
			pulse(1'b1);
			check("div5_only", {3'(i % 5), i[0] ^ 1'b1}, count_out);
			pulse(1'b0);
			check("div2_only", {3'(i % 5), i[0]}, count_out);
		end
	endtask : test_separate
	task automatic test_load;
		preset_load_n = 1'b0;
		preset_value_in = 4'h6;
		step(4);
		check("load", 4'h6, count_out);
		preset_value_in = 4'h9;
		step(4);
		check("transparent", 4'h9, count_out);
		pulse(1'b0);
		pulse(1'b1);
		check("clock_blocked", 4'h9, count_out);
		preset_load_n = 1'b1;
		step(4);
		preset_value_in = 4'h3;
		step(4);
		check("held", 4'h9, count_out);
		for (int u = 5; u <= 7; u++) begin
			preset_load_n = 1'b0;
			preset_value_in = {3'(u), 1'b1};
			step(4);
			preset_load_n = 1'b1;
			step(4);
			pulse(1'b1);
			check("unused_exit", {3'(u) & 3'h3, 1'b1}, count_out);
		end
	endtask : test_load
	task automatic test_clear;
		preset_load_n = 1'b0;
		preset_value_in = 4'hF;
		clear_all_n = 1'b0;
		pulse(1'b0);
		check("clear_wins", 4'h0, count_out);
		clear_all_n = 1'b1;
		step(4);
		check("load_after_clear", 4'hF, count_out);
		preset_load_n = 1'b1;
		step(4);
	endtask : test_clear
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		test_done();
	end
	initial begin
		step(10);
		rst = 1'b0;
		step(1);
		check("reset", 4'h0, count_out);
		test_bcd();
		test_biquinary();
		test_separate();
		test_load();
		test_clear();
		test_done();
	end
endmodule : decade_counter_test
